// [shared/dmae_pkg.sv]
// Constants, types and state layout for the DMA transfer engine
// What this block does
// - Fly-by moves each item in one cycle
// - Fly-by: acknowledge requester, address target only
// - Fly-by counts by target size, ignores requester address
// - Fly-by leaves temporary register untouched
// - Two-cycle: read into temporary, then write out
// - Two-cycle assembles and disassembles unaligned bytes
// - No access straddles a word boundary
// - Fill temporary fully; flush partial at end
// - Suspended process keeps partial temporary contents
// - Reset widths are byte-to-byte, programmable independently
// - Read: target to requester; write: reverse
// - Verify performs reads only, never writes
// - Hold rises three states after request input, one state after software request
// - Arbitrate three states after grant, then access
// - Float bus after hold; rerequest after grant drops
// - Count, end input or withdrawal releases hold
// - End input acts like expired count
// - Demand stops, block continues, single releases each
// - At count end ignore request; reload holds seven
// - End sets mask or reloads, flags; expired count pulses output unless chained without auto-init
// - Release bus between services, rerequest two or more states later
`default_nettype none
package dmae_pkg;

    // ==================================================================
    // Widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W = 24;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int CTRL_W = 11;

    // ==================================================================
    // Register offsets
    localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] REG_TADDR = 8'h04;
    localparam logic [REG_AW-1:0] REG_RADDR = 8'h08;
    localparam logic [REG_AW-1:0] REG_COUNT = 8'h0C;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h10;
    localparam logic [REG_AW-1:0] REG_MASK = 8'h14;
    localparam logic [REG_AW-1:0] REG_SWREQ = 8'h18;

    // Status field positions
    localparam int STAT_TC = 0;
    localparam int STAT_MASK = 1;
    localparam int STAT_SWREQ = 2;
    localparam int STAT_BUSY = 3;
    localparam int STAT_HOLD = 4;
    localparam int STAT_TMP = 5;

    // Bus states the controller keeps the bus while reloading
    localparam logic [2:0] RELOAD_STATES = 3'h7;
    localparam logic MASK_RST = 1'b1;

    // ==================================================================
    // Enumerations
    typedef enum logic [1:0] {CYC_VERIFY, CYC_WRITE, CYC_READ, CYC_RSVD} dmae_cyc_t;
    typedef enum logic [1:0] {XM_DEMAND, XM_BLOCK, XM_SINGLE, XM_RSVD} dmae_xmode_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_HOLD, ST_ARB, ST_SRC, ST_DST, ST_FLY, ST_RELOAD, ST_RELEASE
    } dmae_fsm_t;

    // ==================================================================
    // Control register layout, two_cycle in bit 0
    typedef struct packed {
        logic req_mem;
        logic tgt_mem;
        logic tgt_wide;
        logic req_wide;
        logic chain_loaded;
        logic auto_init;
        dmae_xmode_t xmode;
        dmae_cyc_t cyc;
        logic two_cycle;
    } dmae_ctrl_t;

    localparam dmae_ctrl_t CTRL_RST = 11'h000;

    // Local bus outputs; enables are low while driving
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic addr_oe;
        logic data_oe;
        logic mem_io;
        logic write_read;
        logic low_byte_enable_n;
        logic high_byte_enable_n;
        logic dma_ack;
        logic cycle;
    } dmae_bus_t;

    localparam dmae_bus_t BUS_FLOAT = '{addr_oe: 1'b1, data_oe: 1'b1,
        low_byte_enable_n: 1'b1, high_byte_enable_n: 1'b1, default: '0};

    // Whole state of the engine
    typedef struct packed {
        dmae_fsm_t fsm;
        dmae_ctrl_t ctrl;
        logic [ADDR_W-1:0] tgt_addr;
        logic [ADDR_W-1:0] req_addr;
        logic [CNT_W-1:0] count;
        logic [ADDR_W-1:0] base_t;
        logic [ADDR_W-1:0] base_r;
        logic [CNT_W-1:0] base_c;
        logic mask;
        logic swreq;
        logic tc_flag;
        logic ending;
        logic hold;
        logic eop_drive;
        logic [DATA_W-1:0] temp;
        logic [1:0] tmp_cnt;
        logic [2:0] reload_cnt;
        dmae_bus_t bus;
        logic [REG_DW-1:0] rdata;
        logic [1:0] dreq_sy;
        logic [1:0] eop_sy;
        logic [1:0] bus_grant_ack_sy;
    } dmae_st_t;

    localparam dmae_st_t ST_RST = '{fsm: ST_IDLE, ctrl: CTRL_RST, mask: MASK_RST,
        bus: BUS_FLOAT, eop_sy: 2'h3, default: '0};

endpackage : dmae_pkg
`default_nettype wire

// [hdl/dmae_engine.sv]
// DMA channel transfer engine with bus hold handshake
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dmae_engine (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [dmae_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [dmae_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [dmae_pkg::REG_DW-1:0] reg_rdata_o,
    // Requester and handshake pins
    input wire logic dma_request_input_i,
    input wire logic end_of_process_n_i,
    output logic end_of_process_n_o,
    output logic end_of_process_n_oe_o,
    output logic hold_o,
    input wire logic bus_grant_ack_i,
    // Local bus
    output dmae_pkg::dmae_bus_t bus_o,
    input wire logic [dmae_pkg::DATA_W-1:0] data_i
);
    import dmae_pkg::*;

    dmae_st_t q;
    dmae_st_t d;

    // ==================================================================
    // Helpers

    // Bytes moved by the access now on the bus
    function automatic logic [1:0] nbytes(input dmae_bus_t b);
        return (!b.low_byte_enable_n && !b.high_byte_enable_n) ? 2'h2 : 2'h1;
    endfunction : nbytes

    // One access; a word only when the address is even
    function automatic dmae_bus_t access(input logic [ADDR_W-1:0] a, input logic wide,
                                         input logic mem, input logic wr, input logic ack);
        dmae_bus_t b;
        b = BUS_FLOAT;
        b.addr_oe = 1'b0;
        b.addr = a;
        b.mem_io = mem;
        b.write_read = wr;
        b.dma_ack = ack;
        b.cycle = 1'b1;
        if (wide && !a[0]) begin
            b.low_byte_enable_n = 1'b0;
            b.high_byte_enable_n = 1'b0;
        end else begin
            b.low_byte_enable_n = a[0];
            b.high_byte_enable_n = !a[0];
        end
        return b;
    endfunction : access

    // Plan the next access from the pointers and the temporary register
    function automatic dmae_st_t issue(input dmae_st_t s);
        dmae_st_t r;
        logic src_tgt;
        r = s;
        src_tgt = (s.ctrl.cyc != CYC_WRITE);
        if (!s.ctrl.two_cycle) begin
            // Target addressed, requester by acknowledge only
            r.fsm = ST_FLY;
            r.bus = access(s.tgt_addr, s.ctrl.tgt_wide && (s.count > 24'h000001),
                           s.ctrl.tgt_mem, s.ctrl.cyc == CYC_WRITE,
                           s.ctrl.cyc != CYC_VERIFY);
        end else if (s.tmp_cnt == 2'h2 || (s.tmp_cnt != 2'h0 && (s.ending || s.count == '0))) begin
            // Write phase only once full, or flushing at the end
            r.fsm = ST_DST;
            if (src_tgt) begin
                r.bus = access(s.req_addr, s.ctrl.req_wide && s.tmp_cnt == 2'h2,
                               s.ctrl.req_mem, 1'b1, 1'b1);
            end else begin
                r.bus = access(s.tgt_addr, s.ctrl.tgt_wide && s.tmp_cnt == 2'h2,
                               s.ctrl.tgt_mem, 1'b1, 1'b0);
            end
            r.bus.data_oe = 1'b0;
            // A single byte is copied to both lanes so either lane lands right
            r.bus.data = (nbytes(r.bus) == 2'h2) ? s.temp : {s.temp[7:0], s.temp[7:0]};
        end else begin
            r.fsm = ST_SRC;
            if (src_tgt) begin
                r.bus = access(s.tgt_addr, s.ctrl.tgt_wide && s.tmp_cnt == 2'h0
                               && (s.count > 24'h000001), s.ctrl.tgt_mem, 1'b0, 1'b0);
            end else begin
                r.bus = access(s.req_addr, s.ctrl.req_wide && s.tmp_cnt == 2'h0
                               && (s.count > 24'h000001), s.ctrl.req_mem, 1'b0, 1'b1);
            end
        end
        return r;
    endfunction : issue

    // Drop hold and float every bus line in the same edge
    function automatic dmae_st_t release_bus(input dmae_st_t s);
        dmae_st_t r;
        r = s;
        r.fsm = ST_RELEASE;
        r.hold = 1'b0;
        r.bus = BUS_FLOAT;
        return r;
    endfunction : release_bus

    // Decide after a complete transfer
    function automatic dmae_st_t finish(input dmae_st_t s, input logic tc, input logic eop,
                                        input logic req_act);
        dmae_st_t r;
        r = s;
        r.ending = 1'b0;
        if (tc || eop) begin
            // Expired count and end input take the same path
            r.tc_flag = 1'b1;
            r.swreq = 1'b0;
            if (s.ctrl.auto_init || s.ctrl.chain_loaded) begin
                r.tgt_addr = s.base_t;
                r.req_addr = s.base_r;
                r.count = s.base_c;
            end
            if (s.ctrl.auto_init) begin
                // Bus is kept but idle while the pointers reload
                r.fsm = ST_RELOAD;
                r.reload_cnt = RELOAD_STATES;
                r.bus = BUS_FLOAT;
                r.bus.addr_oe = 1'b0;
                r.eop_drive = tc;
            end else if (s.ctrl.chain_loaded) begin
                r.ctrl.chain_loaded = 1'b0;
                r = release_bus(r);
            end else begin
                r.mask = 1'b1;
                r.eop_drive = tc;
                r = release_bus(r);
            end
        end else if (s.ctrl.xmode == XM_SINGLE) begin
            r = release_bus(r);
        end else if (s.ctrl.xmode == XM_DEMAND && !req_act) begin
            r = release_bus(r);
        end else begin
            r = issue(r);
        end
        return r;
    endfunction : finish

    // ==================================================================
    // Next-state logic
    always_comb begin
        logic [1:0] n;
        logic [7:0] byte_in;
        logic req_act;
        logic bus_grant_ack;
        logic eop_in;
        n = 2'h1;
        byte_in = 8'h00;
        d = q;
        // Second stage is the only reader of the first
        d.dreq_sy = {q.dreq_sy[0], dma_request_input_i};
        d.eop_sy = {q.eop_sy[0], end_of_process_n_i};
        d.bus_grant_ack_sy = {q.bus_grant_ack_sy[0], bus_grant_ack_i};
        req_act = (q.dreq_sy[1] || q.swreq) && !q.mask;
        bus_grant_ack = q.bus_grant_ack_sy[1];
        eop_in = !q.eop_sy[1];
        d.eop_drive = 1'b0;
        d.rdata = '0;

        // Software writes first, so hardware events below win
        if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CTRL: d.ctrl = dmae_ctrl_t'(reg_wdata_i[CTRL_W-1:0]);
                REG_TADDR: begin
                    d.tgt_addr = reg_wdata_i[ADDR_W-1:0];
                    d.base_t = reg_wdata_i[ADDR_W-1:0];
                end
                REG_RADDR: begin
                    d.req_addr = reg_wdata_i[ADDR_W-1:0];
                    d.base_r = reg_wdata_i[ADDR_W-1:0];
                end
                REG_COUNT: begin
                    d.count = reg_wdata_i[CNT_W-1:0];
                    d.base_c = reg_wdata_i[CNT_W-1:0];
                end
                REG_STATUS: if (reg_wdata_i[STAT_TC]) d.tc_flag = 1'b0;
                REG_MASK: d.mask = reg_wdata_i[0];
                REG_SWREQ: d.swreq = reg_wdata_i[0];
                default: ;
            endcase
        end

        // Read data stands in the following cycle only
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL: d.rdata = REG_DW'(q.ctrl);
                REG_TADDR: d.rdata = REG_DW'(q.tgt_addr);
                REG_RADDR: d.rdata = REG_DW'(q.req_addr);
                REG_COUNT: d.rdata = REG_DW'(q.count);
                REG_STATUS: d.rdata = REG_DW'({q.tmp_cnt, q.hold, q.fsm != ST_IDLE,
                                               q.swreq, q.mask, q.tc_flag});
                REG_MASK: d.rdata = REG_DW'(q.mask);
                REG_SWREQ: d.rdata = REG_DW'(q.swreq);
                default: d.rdata = '0;
            endcase
        end

        // Channel sequencer, one bus state per clock
        case (q.fsm)
            ST_IDLE: begin
                if (req_act) begin
                    d.hold = 1'b1;
                    d.fsm = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (bus_grant_ack) d.fsm = ST_ARB;
            end
            ST_ARB: begin
                // Single channel: arbitration settles here, access follows
                d = issue(d);
            end
            ST_SRC: begin
                n = nbytes(q.bus);
                byte_in = q.bus.addr[0] ? data_i[15:8] : data_i[7:0];
                if (q.ctrl.cyc != CYC_VERIFY) begin
                    // Bytes gather in stream order, low byte first
                    if (n == 2'h2) begin
                        d.temp = data_i;
                        d.tmp_cnt = 2'h2;
                    end else if (q.tmp_cnt == 2'h0) begin
                        d.temp[7:0] = byte_in;
                        d.tmp_cnt = 2'h1;
                    end else begin
                        d.temp[15:8] = byte_in;
                        d.tmp_cnt = 2'h2;
                    end
                end
                if (q.ctrl.cyc == CYC_WRITE) d.req_addr = q.req_addr + ADDR_W'(n);
                else d.tgt_addr = q.tgt_addr + ADDR_W'(n);
                d.count = q.count - CNT_W'(n);
                if (eop_in) d.ending = 1'b1;
                if (q.ctrl.cyc == CYC_VERIFY) begin
                    d = finish(d, d.count == '0, d.ending, req_act);
                end else if (d.tmp_cnt == 2'h2 || d.count == '0 || d.ending) begin
                    d = issue(d);
                end else if (q.ctrl.xmode == XM_DEMAND && !req_act) begin
                    // Partial bytes stay for the restart
                    d = release_bus(d);
                end else begin
                    d = issue(d);
                end
            end
            ST_DST: begin
                n = nbytes(q.bus);
                if (q.ctrl.cyc == CYC_WRITE) d.tgt_addr = q.tgt_addr + ADDR_W'(n);
                else d.req_addr = q.req_addr + ADDR_W'(n);
                if (n == 2'h2 || q.tmp_cnt == 2'h1) begin
                    d.tmp_cnt = 2'h0;
                end else begin
                    d.temp[7:0] = q.temp[15:8];
                    d.tmp_cnt = 2'h1;
                end
                if (d.tmp_cnt != 2'h0) d = issue(d);
                else d = finish(d, d.count == '0, d.ending, req_act);
            end
            ST_FLY: begin
                // Count steps by target size; temporary register stays put
                n = nbytes(q.bus);
                d.tgt_addr = q.tgt_addr + ADDR_W'(n);
                d.count = q.count - CNT_W'(n);
                d = finish(d, d.count == '0, eop_in, req_act);
            end
            ST_RELOAD: begin
                if (q.reload_cnt == 3'h1) d = release_bus(d);
                else d.reload_cnt = q.reload_cnt - 3'h1;
            end
            ST_RELEASE: begin
                // No new request until the grant has gone away
                if (!bus_grant_ack) d.fsm = ST_IDLE;
            end
            default: d.fsm = ST_IDLE;
        endcase
    end

    // ==================================================================
    // State register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_o = q.rdata;
    assign hold_o = q.hold;
    assign bus_o = q.bus;
    assign end_of_process_n_o = !q.eop_drive;
    assign end_of_process_n_oe_o = !q.eop_drive;

endmodule : dmae_engine
`default_nettype wire

// [tb/dmae_engine_asserts.sv]
// Port-level checks for the DMA transfer engine
`timescale 1ns/1ps
`default_nettype none
module dmae_engine_asserts (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [dmae_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [dmae_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Handshake and bus
    input wire logic dma_request_input_i,
    input wire logic end_of_process_n_o,
    input wire logic end_of_process_n_oe_o,
    input wire logic hold_o,
    input wire logic bus_grant_ack_i,
    input wire dmae_pkg::dmae_bus_t bus_o
);
    import dmae_pkg::*;
    // ==========
    // Shadow of the control word, safe because software writes it only while idle
    dmae_ctrl_t ctrl_q;
    logic [2:0] sw_age_q;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= CTRL_RST;
            sw_age_q <= 3'h7;
        end else begin
            if (reg_wr_i && reg_addr_i == REG_CTRL)
                ctrl_q <= dmae_ctrl_t'(reg_wdata_i[CTRL_W-1:0]);
            if (reg_wr_i && reg_addr_i == REG_SWREQ && reg_wdata_i[0])
                sw_age_q <= 3'h0;
            else if (sw_age_q != 3'h7)
                sw_age_q <= sw_age_q + 3'h1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // ==========
    // Properties
    sequence s_eop_pulse;
        !end_of_process_n_o ##1 end_of_process_n_oe_o;
    endsequence
    a_float_idle: assert property (!hold_o |-> bus_o.addr_oe && bus_o.data_oe)
        else $error("bus driven without hold");
    a_rereq_wait: assert property (!hold_o && bus_grant_ack_i |=> !hold_o)
        else $error("hold raised before grant dropped");
    a_access_granted: assert property (bus_o.cycle |-> hold_o && $past(bus_grant_ack_i, 2))
        else $error("access without granted bus");
    a_hold_cause: assert property ($rose(hold_o) |-> $past(dma_request_input_i, 2) || sw_age_q < 3'h4)
        else $error("hold without request");
    a_verify_reads: assert property (ctrl_q.cyc == CYC_VERIFY && bus_o.cycle |-> !bus_o.write_read && !bus_o.dma_ack)
        else $error("verify cycle wrote");
    a_flyby_dir: assert property (!ctrl_q.two_cycle && ctrl_q.cyc != CYC_VERIFY && bus_o.cycle |-> bus_o.dma_ack && bus_o.mem_io == ctrl_q.tgt_mem && bus_o.write_read == (ctrl_q.cyc == CYC_WRITE))
        else $error("fly-by access shape wrong");
    a_no_straddle: assert property (bus_o.cycle && !bus_o.low_byte_enable_n && !bus_o.high_byte_enable_n |-> !bus_o.addr[0])
        else $error("word access on odd address");
    a_eop_pulse: assert property ($fell(end_of_process_n_oe_o) |-> s_eop_pulse)
        else $error("end pulse malformed");
    a_single_release: assert property (ctrl_q.xmode == XM_SINGLE && !ctrl_q.two_cycle && bus_o.cycle |=> !hold_o)
        else $error("single mode kept the bus");
endmodule : dmae_engine_asserts
bind dmae_engine dmae_engine_asserts u_chk (.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .dma_request_input_i, .end_of_process_n_o, .end_of_process_n_oe_o, .hold_o,
    .bus_grant_ack_i, .bus_o);
`default_nettype wire

// [tb/dmae_host_model.sv]
// Host hold handshake and byte-lane memory facing the engine
`timescale 1ns/1ps
`default_nettype none
module dmae_host_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Hold handshake
    input wire logic hold_i,
    input wire logic [3:0] gnt_dly_i,
    output logic bus_grant_ack_o,
    // Local bus
    input wire dmae_pkg::dmae_bus_t bus_i,
    output logic [dmae_pkg::DATA_W-1:0] data_o
);
    import dmae_pkg::*;
    logic [3:0] wait_q;
    logic [DATA_W-1:0] junk_q;
    // Grant after a chosen delay, withdraw it one state after hold falls
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_grant_ack_o <= 1'b0;
            wait_q <= 4'h0;
            junk_q <= 16'hA5C3;
        end else begin
            junk_q <= ~{junk_q[14:0], junk_q[15]};
            if (!hold_i) begin
                bus_grant_ack_o <= 1'b0;
                wait_q <= 4'h0;
            end else if (wait_q >= gnt_dly_i)
                bus_grant_ack_o <= 1'b1;
            else
                wait_q <= wait_q + 4'h1;
        end
    end
    // Idle lanes carry a moving pattern so stale data is never mistaken for good
    always_comb begin
        data_o = junk_q;
        if (bus_i.cycle && !bus_i.write_read && !bus_i.low_byte_enable_n)
            data_o[7:0] = {bus_i.addr[7:1], 1'b0} ^ 8'h5A;
        if (bus_i.cycle && !bus_i.write_read && !bus_i.high_byte_enable_n)
            data_o[15:8] = {bus_i.addr[7:1], 1'b1} ^ 8'h5A;
    end
endmodule : dmae_host_model
`default_nettype wire

// [tb/dma_transfer_and_bus_handshake_tb.sv]
// Self-checking bench for the DMA transfer engine
`timescale 1ns/1ps
`default_nettype none
module dma_transfer_and_bus_handshake_tb;
    import dmae_pkg::*;
    logic clock_i, arst_n_i, reg_wr_i, reg_rd_i, dreq, eop_drv, eop_arm, gnt, hold_o;
    logic eop_o, eop_oe;
    logic [REG_AW-1:0] reg_addr_i;
    logic [REG_DW-1:0] reg_wdata_i, reg_rdata_o;
    logic [DATA_W-1:0] data_i;
    logic [3:0] gdly;
    dmae_bus_t bus_o;
    dmae_bus_t acc_q[$];
    int n_mismatch, checked, seed, eops, held;
    // Pulled-up end-of-process pin shared by bench and engine
    wire eop_w = eop_drv && (eop_oe || eop_o);
    dmae_engine u_dut (.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .dma_request_input_i(dreq), .end_of_process_n_i(eop_w),
        .end_of_process_n_o(eop_o), .end_of_process_n_oe_o(eop_oe), .hold_o,
        .bus_grant_ack_i(gnt), .bus_o, .data_i);
    dmae_host_model u_host (.clock_i, .arst_n_i, .hold_i(hold_o), .gnt_dly_i(gdly),
        .bus_grant_ack_o(gnt), .bus_i(bus_o), .data_o(data_i));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // Record accesses, end pulses and held states after the last access
    always @(posedge clock_i) begin
        if (bus_o.cycle)
            acc_q.push_back(bus_o);
        if (eop_arm && acc_q.size() == 3)
            eop_drv <= 1'b0;
        if (!eop_oe)
            eops++;
        held = bus_o.cycle ? 0 : held + int'(hold_o);
    end
    // ==========
    // Tasks
    function automatic logic [7:0] srcb(input logic [23:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction : srcb
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        d = reg_rdata_o;
    endtask : rd
    // Program one process, start it and wait until the bus has been quiet a while
    task automatic run(input dmae_ctrl_t c, input logic [23:0] ta, ra, cnt, input bit sw);
        int idle;
        wr(REG_TADDR, {8'h00, ta});
        wr(REG_RADDR, {8'h00, ra});
        wr(REG_COUNT, {8'h00, cnt});
        wr(REG_CTRL, {21'h0, c});
        wr(REG_STATUS, 32'h1);
        wr(REG_MASK, 32'h0);
        acc_q.delete();
        eops = 0;
        gdly <= 4'($random(seed));
        if (sw)
            wr(REG_SWREQ, 32'h1);
        else begin
            @(posedge clock_i);
            dreq <= 1'b1;
            repeat (2) @(posedge clock_i);
            @(negedge clock_i);
            chk("hold early", 0, hold_o);
            @(negedge clock_i);
            chk("hold late", 1, hold_o);
        end
        idle = 0;
        while (idle < 12) begin
            @(negedge clock_i);
            idle = (hold_o || gnt) ? 0 : idle + 1;
        end
        @(posedge clock_i);
        dreq <= 1'b0;
    endtask : run
    task automatic conclude();
        $display("Mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial begin
        #(60000 * 100);
        n_mismatch++;
        conclude();
    end
    // ==========
    // Main sequence
    initial begin
        dmae_ctrl_t c;
        logic [23:0] ta, ra;
        logic [31:0] r;
        int n, step, j;
        seed = 88877;
        {n_mismatch, checked, eops, held} = '0;
        {arst_n_i, reg_wr_i, reg_rd_i, dreq, eop_arm} = '0;
        eop_drv = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        gdly = 4'h0;
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        rd(REG_CTRL, r);
        chk("ctrl reset", 0, r);
        rd(REG_STATUS, r);
        chk("status reset", 32'h2, r);
        rd(8'hFC, r);
        chk("unmapped", 0, r);
        // Fly-by across cycle kinds, widths and modes
        for (int k = 0; k < 6; k++) begin
            c = CTRL_RST;
            c.cyc = dmae_cyc_t'(k % 3);
            c.xmode = dmae_xmode_t'(k / 2);
            c.tgt_wide = k[0];
            c.tgt_mem = k[1];
            step = k[0] ? 2 : 1;
            ta = 24'($random(seed)) & 24'h0FFFF0;
            n = (($random(seed) & 1) + 1) * 2;
            run(c, ta, 24'($random(seed)), 24'(n), 1'b0);
            chk("flyby count", n / step, acc_q.size());
            foreach (acc_q[i]) begin
                chk("flyby addr", ta + i * step, acc_q[i].addr);
                chk("flyby ack", c.cyc != CYC_VERIFY, acc_q[i].dma_ack);
                chk("flyby dir", c.cyc == CYC_WRITE, acc_q[i].write_read);
            end
            chk("release", 0, held);
            chk("end pulses", 1, eops);
            rd(REG_STATUS, r);
            chk("tc mask", 2'h3, r[1:0]);
            chk("temp idle", 0, r[6:5]);
        end
        // Two-cycle with unaligned source and odd counts
        for (int k = 0; k < 2; k++) begin
            c = CTRL_RST;
            c.two_cycle = 1'b1;
            c.cyc = CYC_WRITE;
            c.xmode = XM_BLOCK;
            c.req_wide = !k[0];
            c.tgt_wide = k[0];
            ta = 24'($random(seed)) & 24'h0FFFF0 | 24'(k);
            ra = 24'($random(seed)) & 24'h0FFFF0 | 24'h000001;
            n = 3 + 2 * k;
            run(c, ta, ra, 24'(n), 1'b0);
            j = 0;
            foreach (acc_q[i]) begin
                for (int b = 0; b < 2; b++) begin
                    if (acc_q[i].write_read && !(b ? acc_q[i].high_byte_enable_n
                            : acc_q[i].low_byte_enable_n)) begin
                        chk("dest addr", ta + j, {acc_q[i].addr[23:1], b[0]});
                        chk("dest byte", srcb(ra + j), b ? acc_q[i].data[15:8]
                            : acc_q[i].data[7:0]);
                        j++;
                    end
                end
            end
            chk("dest total", n, j);
        end
        // External end input stops a long block early
        c = CTRL_RST;
        c.cyc = CYC_READ;
        c.xmode = XM_BLOCK;
        c.chain_loaded = 1'b1;
        eop_arm = 1'b1;
        run(c, 24'h000400, 24'h000000, 24'h000028, 1'b0);
        eop_arm = 1'b0;
        eop_drv <= 1'b1;
        chk("eop early stop", 1, acc_q.size() < 40);
        rd(REG_STATUS, r);
        chk("eop as tc", 2'h3, r[1:0]);
        rd(REG_CTRL, r);
        chk("chain clear", 0, r[6]);
        // Software request on an auto-initialising channel
        c.auto_init = 1'b1;
        c.cyc = CYC_WRITE;
        run(c, 24'h000200, 24'h000000, 24'h000002, 1'b1);
        chk("reload hold", 7, held);
        chk("reload pulse", 1, eops);
        rd(REG_STATUS, r);
        chk("reload status", 32'h1, r & 32'h7);
        rd(REG_COUNT, r);
        chk("reload count", 2, r);
        conclude();
    end
endmodule : dma_transfer_and_bus_handshake_tb
`default_nettype wire
